// ===== core/ppf_consts.vh
// constants for the process regulator: scaling, ticks, terminal codes, modes, delays
// included by core/ppf_regulator.v and core/ppf_mul_frac.v
`ifndef PPF_CONSTS_VH
`define PPF_CONSTS_VH

// clock and sample tick
`define PPF_CLK_HZ 25000000
`define PPF_TICK_US 1000
`define PPF_TICK_CYC ((`PPF_CLK_HZ / 1000000) * `PPF_TICK_US)
`define PPF_TICK_W 16
`define PPF_TICKS_PER_S 1000

// value widths: percent in 0.1 % steps, 1000 = 100.0 %
`define PPF_W 16
`define PPF_ACC_W 40
`define PPF_FULL 16'h03E8
`define PPF_GAIN_ONE 16'h03E8
`define PPF_ZERO 16'h0000

// gain scale: shift applied after proportional gain
`define PPF_SCALE_W 3

// input terminal function codes
`define PPF_FN_W 6
`define PPF_FN_ICLR 6'h15
`define PPF_FN_BYPASS 6'h17
`define PPF_FN_GAIN2 6'h18
`define PPF_TERMS 5

// wake modes
`define PPF_WAKE_BELOW 2'h0
`define PPF_WAKE_ABOVE 2'h1
`define PPF_WAKE_BEYOND 2'h2

// delays in 0.1 s, converted to ticks
`define PPF_DT_W 16
`define PPF_TICKS_PER_DS 24'h00_0064
`define PPF_SLEEP_DT_DEF 16'h0258
`define PPF_CNT_W 24

`endif

// ===== core/ppf_mul_frac.v
// signed value times unsigned ratio in 0.1 % steps (1000 = unity)
// purely combinational; caller registers the result
`timescale 1ns/1ns
`include "ppf_consts.vh"
module ppf_mul_frac
(
    // operands
    input wire signed [`PPF_ACC_W-1:0] val_i,
    input wire [`PPF_W-1:0] ratio_i,
    // result
    output wire signed [`PPF_ACC_W-1:0] prod_o
);
    wire signed [`PPF_ACC_W+`PPF_W:0] full_w;
    wire signed [`PPF_ACC_W+`PPF_W:0] quot_w;

    assign full_w = val_i * $signed({1'b0, ratio_i});
    assign quot_w = full_w / $signed({1'b0, `PPF_GAIN_ONE});
    assign prod_o = quot_w[`PPF_ACC_W-1:0];
endmodule // ppf_mul_frac

// ===== core/ppf_regulator.v
// process regulator: pid terms, filter, limits, pre-run, sleep, bypass
// assumes config inputs are static per tick; terminals are async pins
//
// How it works
// R1: proportional term is error times gain
// R2: gain 0..6553.5 percent plus fine scale shift
// R3: integral reaches error after one integral time
// R4: clear function terminal zeroes integral accumulator
// R5: derivative term is error slope times time
// R6: reference times feed-forward gain is added
// R7: low-pass filter on output, zero means none
// R8: output clamped between upper and lower limit
// R9: output multiplied by output scale factor
// R10: second gain terminal selects alternate gain
// R11: run with pre-frequency ramps open loop first
// R12: feedback above exit level starts closed loop
// R13: feedback low for delay raises failure trip
// R14: low frequency run enters sleep, output stopped
// R15: sleep holds until wake condition true
// R16: wake modes below, above, error beyond level
// R17: bypass terminal runs open loop until released
// R18: unipolar output, 100 percent is max frequency
// R19: sleep requires low frequency for sleep delay
// R20: terms evaluated per tick, state zero reset
`timescale 1ns/1ns
`include "ppf_consts.vh"
module ppf_regulator
(
    // clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // run and process values, 0.1 % units
    input wire run_i,
    input wire [`PPF_W-1:0] reference_i,
    input wire [`PPF_W-1:0] feedback_i,
    input wire [`PPF_W-1:0] manual_command_i,
    // gains, 0.1 % units, times in ticks
    input wire [`PPF_W-1:0] proportional_gain_i,
    input wire [`PPF_SCALE_W-1:0] gain_scale_shift_i,
    input wire [`PPF_W-1:0] alternate_gain_i,
    input wire [`PPF_W-1:0] integral_time_i,
    input wire [`PPF_W-1:0] derivative_time_i,
    input wire [`PPF_W-1:0] feed_forward_gain_i,
    input wire [`PPF_W-1:0] output_scale_i,
    input wire [3:0] output_lowpass_setting_i,
    input wire [`PPF_W-1:0] limit_high_i,
    input wire [`PPF_W-1:0] limit_low_i,
    // pre-regulation, sleep and wake
    input wire [`PPF_W-1:0] pre_regulation_frequency_i,
    input wire [`PPF_W-1:0] pre_regulation_exit_level_i,
    input wire [`PPF_DT_W-1:0] pre_regulation_delay_i,
    input wire [`PPF_W-1:0] sleep_frequency_threshold_i,
    input wire [`PPF_DT_W-1:0] sleep_delay_i,
    input wire [`PPF_W-1:0] wake_threshold_i,
    input wire [1:0] wake_mode_i,
    // multi-function terminals and their codes
    input wire [`PPF_TERMS-1:0] terminal_i,
    input wire [`PPF_TERMS*`PPF_FN_W-1:0] terminal_fn_i,
    // command and status
    output wire [`PPF_W-1:0] frequency_command_o,
    output wire [`PPF_W-1:0] regulator_output_o,
    output wire pre_regulation_failure_trip_o,
    output wire sleep_active_o,
    output wire closed_loop_o,
    output wire output_blocked_o
);
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_PRE = 5'h02;
    localparam [4:0] ST_PID = 5'h04;
    localparam [4:0] ST_SLEEP = 5'h08;
    localparam [4:0] ST_FAIL = 5'h10;

    // any active terminal carrying a given function code
    function fn_active;
        input [`PPF_TERMS-1:0] lvl;
        input [`PPF_TERMS*`PPF_FN_W-1:0] fns;
        input [`PPF_FN_W-1:0] code;
        integer k;
        begin
            fn_active = 1'b0;
            for (k = 0; k < `PPF_TERMS; k = k + 1)
            begin
                if (lvl[k] && fns[k*`PPF_FN_W +: `PPF_FN_W] == code)
                begin
                    fn_active = 1'b1;
                end
            end
        end
    endfunction

    // terminal synchronisers, three stages
    reg [`PPF_TERMS-1:0] s1_reg;
    reg [`PPF_TERMS-1:0] s2_reg;
    reg [`PPF_TERMS-1:0] s3_reg;
    reg [`PPF_TERMS-1:0] term_reg;
    reg [`PPF_TERMS-1:0] term_next;
    genvar g;
    generate
        for (g = 0; g < `PPF_TERMS; g = g + 1)
        begin : g_sync
            always @*
            begin
                term_next[g] = term_reg[g];
                if (s2_reg[g] == s3_reg[g])
                begin
                    term_next[g] = s3_reg[g];
                end
            end
        end
    endgenerate

    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s1_reg <= {`PPF_TERMS{1'b0}};
            s2_reg <= {`PPF_TERMS{1'b0}};
            s3_reg <= {`PPF_TERMS{1'b0}};
            term_reg <= {`PPF_TERMS{1'b0}};
        end
        else
        begin
            s1_reg <= terminal_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            term_reg <= term_next;
        end
    end

    wire iclr_w = fn_active(term_reg, terminal_fn_i, `PPF_FN_ICLR);
    wire bypass_w = fn_active(term_reg, terminal_fn_i, `PPF_FN_BYPASS);
    wire gain2_w = fn_active(term_reg, terminal_fn_i, `PPF_FN_GAIN2);

    // sample tick
    reg [`PPF_TICK_W-1:0] tick_cnt_reg;
    wire tick_w = (tick_cnt_reg == `PPF_TICK_CYC - 1); // see R20
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tick_cnt_reg <= {`PPF_TICK_W{1'b0}};
        end
        else if (tick_w)
        begin
            tick_cnt_reg <= {`PPF_TICK_W{1'b0}};
        end
        else
        begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
        end
    end

    // error and gain choice
    wire signed [`PPF_ACC_W-1:0] ref_w = {{(`PPF_ACC_W-`PPF_W){1'b0}},
        reference_i};
    wire signed [`PPF_ACC_W-1:0] fb_w = {{(`PPF_ACC_W-`PPF_W){1'b0}},
        feedback_i};
    wire signed [`PPF_ACC_W-1:0] err_w = ref_w - fb_w; // see R1
    wire [`PPF_W-1:0] kp_w = gain2_w ? alternate_gain_i
        : proportional_gain_i; // see R10

    reg signed [`PPF_ACC_W-1:0] int_acc_reg;
    reg signed [`PPF_ACC_W-1:0] prev_err_reg;
    reg signed [`PPF_ACC_W-1:0] filt_reg;

    wire signed [`PPF_ACC_W-1:0] p_raw_w;
    ppf_mul_frac u_p
    (
        .val_i(err_w),
        .ratio_i(kp_w),
        .prod_o(p_raw_w)
    );
    wire signed [`PPF_ACC_W-1:0] p_w =
        p_raw_w >>> gain_scale_shift_i; // see R2

    // integral: acc sums err each tick, term = acc / time, time in ticks
    wire [`PPF_W-1:0] ti_w = (integral_time_i == `PPF_ZERO) ? 16'h0001
        : integral_time_i;
    wire signed [`PPF_ACC_W-1:0] i_term_w = (integral_time_i == `PPF_ZERO)
        ? {`PPF_ACC_W{1'b0}}
        : int_acc_reg / $signed({1'b0, ti_w}); // see R3
    // integral gain is unity unless the second gain terminal selects the alternate gain (alternate replaces both)
    wire signed [`PPF_ACC_W-1:0] i_raw_w;
    ppf_mul_frac u_i
    (
        .val_i(i_term_w),
        .ratio_i(gain2_w ? alternate_gain_i : `PPF_GAIN_ONE), // see R10
        .prod_o(i_raw_w)
    );

    // derivative: slope per tick times time in ticks
    wire signed [`PPF_ACC_W-1:0] d_w = (err_w - prev_err_reg)
        * $signed({1'b0, derivative_time_i}); // see R5

    wire signed [`PPF_ACC_W-1:0] ff_w;
    ppf_mul_frac u_ff
    (
        .val_i(ref_w),
        .ratio_i(feed_forward_gain_i),
        .prod_o(ff_w)
    );

    wire signed [`PPF_ACC_W-1:0] sum_w = p_w + i_raw_w + d_w + ff_w; // see R6

    // first order filter, shift by setting
    wire signed [`PPF_ACC_W-1:0] filt_next_w =
        (output_lowpass_setting_i == 4'h0) ? sum_w // see R7
        : filt_reg + ((sum_w - filt_reg) >>> output_lowpass_setting_i);

    // clamp, unipolar
    wire signed [`PPF_ACC_W-1:0] hi_w = {{(`PPF_ACC_W-`PPF_W){1'b0}},
        limit_high_i};
    wire signed [`PPF_ACC_W-1:0] lo_w = {{(`PPF_ACC_W-`PPF_W){1'b0}},
        limit_low_i};
    wire signed [`PPF_ACC_W-1:0] clamp_w = (filt_next_w > hi_w) ? hi_w
        : (filt_next_w < lo_w) ? lo_w : filt_next_w; // see R8
    wire signed [`PPF_ACC_W-1:0] uni_w = (clamp_w < 0)
        ? {`PPF_ACC_W{1'b0}} : clamp_w; // see R18
    wire signed [`PPF_ACC_W-1:0] scaled_w;
    ppf_mul_frac u_out
    (
        .val_i(uni_w),
        .ratio_i(output_scale_i),
        .prod_o(scaled_w)
    );
    wire signed [`PPF_ACC_W-1:0] full_w = {{(`PPF_ACC_W-`PPF_W){1'b0}},
        `PPF_FULL};
    wire [`PPF_W-1:0] regulator_output_w = (scaled_w > full_w) ? `PPF_FULL
        : scaled_w[`PPF_W-1:0]; // see R9

    // sequencing
    reg [4:0] state_reg;
    reg [4:0] state_next;
    reg [`PPF_CNT_W-1:0] pre_cnt_reg;
    reg [`PPF_CNT_W-1:0] sleep_cnt_reg;
    reg [`PPF_W-1:0] out_reg;
    reg [`PPF_W-1:0] cmd_reg;
    reg [`PPF_W-1:0] cmd_next;

    wire [`PPF_CNT_W-1:0] pre_lim_w = pre_regulation_delay_i
        * `PPF_TICKS_PER_DS;
    wire [`PPF_CNT_W-1:0] sleep_lim_w = sleep_delay_i * `PPF_TICKS_PER_DS;
    wire above_exit_w = feedback_i > pre_regulation_exit_level_i;
    wire low_freq_w = out_reg < sleep_frequency_threshold_i;
    wire signed [`PPF_ACC_W-1:0] wake_lvl_w = {{(`PPF_ACC_W-`PPF_W){1'b0}},
        wake_threshold_i};
    reg wake_w;
    always @*
    begin
        case (wake_mode_i) // see R16
            `PPF_WAKE_BELOW: wake_w = feedback_i < wake_threshold_i;
            `PPF_WAKE_ABOVE: wake_w = feedback_i > wake_threshold_i;
            `PPF_WAKE_BEYOND: wake_w = err_w > wake_lvl_w;
            default: wake_w = 1'b0;
        endcase
    end

    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (run_i && pre_regulation_frequency_i != `PPF_ZERO)
                begin
                    state_next = ST_PRE; // see R11
                end
                else if (run_i)
                begin
                    state_next = ST_PID;
                end
            end
            ST_PRE:
            begin
                if (!run_i)
                begin
                    state_next = ST_IDLE;
                end
                else if (above_exit_w)
                begin
                    state_next = ST_PID; // see R12
                end
                else if (pre_regulation_delay_i != `PPF_ZERO
                    && pre_cnt_reg >= pre_lim_w)
                begin
                    state_next = ST_FAIL; // see R13
                end
            end
            ST_PID:
            begin
                if (!run_i)
                begin
                    state_next = ST_IDLE;
                end
                else if (!bypass_w && sleep_cnt_reg >= sleep_lim_w
                    && low_freq_w)
                begin
                    state_next = ST_SLEEP; // see R14
                end
            end
            ST_SLEEP:
            begin
                if (!run_i)
                begin
                    state_next = ST_IDLE;
                end
                else if (wake_w)
                begin
                    state_next = ST_PID; // see R15
                end
            end
            ST_FAIL:
            begin
                if (!run_i)
                begin
                    state_next = ST_IDLE;
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    wire in_pid_w = (state_reg == ST_PID);
    wire loop_w = in_pid_w && !bypass_w; // see R17

    always @*
    begin
        cmd_next = `PPF_ZERO;
        if (state_reg == ST_PRE)
        begin
            cmd_next = pre_regulation_frequency_i; // see R11
        end
        else if (in_pid_w && bypass_w)
        begin
            cmd_next = manual_command_i; // see R17
        end
        else if (in_pid_w)
        begin
            cmd_next = out_reg;
        end
    end

    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_reg <= ST_IDLE;
            int_acc_reg <= {`PPF_ACC_W{1'b0}}; // see R20
            prev_err_reg <= {`PPF_ACC_W{1'b0}};
            filt_reg <= {`PPF_ACC_W{1'b0}};
            out_reg <= `PPF_ZERO;
            cmd_reg <= `PPF_ZERO;
            pre_cnt_reg <= {`PPF_CNT_W{1'b0}};
            sleep_cnt_reg <= {`PPF_CNT_W{1'b0}};
        end
        else
        begin
            state_reg <= state_next;
            cmd_reg <= cmd_next;
            if (iclr_w || !loop_w)
            begin
                int_acc_reg <= {`PPF_ACC_W{1'b0}}; // see R4
            end
            else if (tick_w)
            begin
                int_acc_reg <= int_acc_reg + err_w; // see R3
            end
            if (!loop_w)
            begin
                filt_reg <= {`PPF_ACC_W{1'b0}};
                prev_err_reg <= err_w;
                out_reg <= `PPF_ZERO;
            end
            else if (tick_w)
            begin
                filt_reg <= filt_next_w; // see R20
                prev_err_reg <= err_w;
                out_reg <= regulator_output_w;
            end
            if (state_reg != ST_PRE || above_exit_w)
            begin
                pre_cnt_reg <= {`PPF_CNT_W{1'b0}};
            end
            else if (tick_w && pre_cnt_reg < pre_lim_w)
            begin
                pre_cnt_reg <= pre_cnt_reg + 1'b1; // see R13
            end
            if (!loop_w || !low_freq_w)
            begin
                sleep_cnt_reg <= {`PPF_CNT_W{1'b0}};
            end
            else if (tick_w && sleep_cnt_reg < sleep_lim_w)
            begin
                sleep_cnt_reg <= sleep_cnt_reg + 1'b1; // see R19
            end
        end
    end

    assign frequency_command_o = cmd_reg;
    assign regulator_output_o = out_reg;
    assign pre_regulation_failure_trip_o = (state_reg == ST_FAIL);
    assign sleep_active_o = (state_reg == ST_SLEEP);
    assign closed_loop_o = loop_w;
    assign output_blocked_o = (state_reg == ST_FAIL)
        || (state_reg == ST_SLEEP);
endmodule // ppf_regulator

// ===== dv/ppf_regulator_properties.sv
// port-level checks for the process regulator
// bound into ppf_regulator; sees only its ports
`timescale 1ns/1ns
`include "ppf_consts.vh"
module ppf_regulator_properties
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // inputs watched
    input wire logic run_i,
    input wire logic [`PPF_W-1:0] feedback_i,
    input wire logic [`PPF_W-1:0] limit_high_i,
    input wire logic [`PPF_W-1:0] limit_low_i,
    input wire logic [`PPF_W-1:0] output_scale_i,
    input wire logic [`PPF_W-1:0] pre_regulation_frequency_i,
    input wire logic [`PPF_W-1:0] pre_regulation_exit_level_i,
    input wire logic [`PPF_TERMS-1:0] terminal_i,
    input wire logic [`PPF_TERMS*`PPF_FN_W-1:0] terminal_fn_i,
    // outputs watched
    input wire logic [`PPF_W-1:0] frequency_command_o,
    input wire logic [`PPF_W-1:0] regulator_output_o,
    input wire logic pre_regulation_failure_trip_o,
    input wire logic sleep_active_o,
    input wire logic closed_loop_o,
    input wire logic output_blocked_o
);
    logic byp_now;
    logic [5:0] byp_hist;
    logic quiet;
    always_comb
    begin
        byp_now = 1'b0;
        for (int k = 0; k < `PPF_TERMS; k++)
            if (terminal_i[k] && terminal_fn_i[k*6 +: 6] == `PPF_FN_BYPASS)
                byp_now = 1'b1;
    end
    always_ff @(posedge clk_i or negedge rst_b_i)
        if (!rst_b_i)
            byp_hist <= '0;
        else
            byp_hist <= {byp_hist[4:0], byp_now};
    assign quiet = (byp_hist == '0) && !byp_now;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence pre_start_s;
        $rose(run_i) && pre_regulation_frequency_i != '0 && quiet
            && feedback_i <= pre_regulation_exit_level_i;
    endsequence
    sequence pre_hold_s;
        (run_i && quiet && feedback_i <= pre_regulation_exit_level_i)[*2];
    endsequence
    sequence in_pre_s;
        run_i && quiet && !closed_loop_o && !output_blocked_o
            && pre_regulation_frequency_i != '0
            && frequency_command_o == pre_regulation_frequency_i;
    endsequence

    reset_out_a: assert property ($rose(rst_b_i) |->
        frequency_command_o == '0 && regulator_output_o == '0
        && !closed_loop_o && !output_blocked_o)
        else $error("outputs not cleared after reset");
    pre_cmd_a: assert property (pre_start_s ##1 pre_hold_s |->
        frequency_command_o == pre_regulation_frequency_i && !closed_loop_o)
        else $error("pre-regulation command wrong");
    pre_exit_a: assert property (in_pre_s ##1
        (run_i && quiet && feedback_i > pre_regulation_exit_level_i)[*2]
        |-> closed_loop_o)
        else $error("closed loop not entered");
    fail_block_a: assert property (pre_regulation_failure_trip_o |->
        output_blocked_o && !closed_loop_o)
        else $error("trip does not block");
    sleep_block_a: assert property (sleep_active_o |->
        output_blocked_o && !closed_loop_o)
        else $error("sleep does not stop loop");
    sleep_cmd_a: assert property ($past(sleep_active_o)
        && sleep_active_o |-> frequency_command_o == '0)
        else $error("command present in sleep");
    limit_range_a: assert property ($changed(regulator_output_o)
        && closed_loop_o && $past(closed_loop_o)
        && limit_low_i <= limit_high_i && output_scale_i == `PPF_GAIN_ONE
        |-> regulator_output_o <= limit_high_i
        && regulator_output_o >= limit_low_i)
        else $error("output outside limits");
    bypass_open_a: assert property (byp_now[*6] |-> !closed_loop_o)
        else $error("loop still closed in bypass");
    idle_cmd_a: assert property ((!run_i && quiet)[*3]
        |-> frequency_command_o == '0)
        else $error("command present while stopped");
endmodule // ppf_regulator_properties

bind ppf_regulator ppf_regulator_properties prop_u (.*);

// ===== dv/ppf_process_model.sv
// process sensor and input terminal model
// feedback ramps toward the requested level; terminals follow requests
`timescale 1ns/1ns
module ppf_process_model
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // requested level, ramp step per clock, terminal requests
    input wire logic [15:0] level_i,
    input wire logic [15:0] step_i,
    input wire logic [4:0] term_req_i,
    // sensor and terminal pins
    output logic [15:0] feedback_o,
    output logic [4:0] terminal_o
);
    always_ff @(posedge clk_i or negedge rst_b_i)
        if (!rst_b_i)
        begin
            feedback_o <= '0;
            terminal_o <= '0;
        end
        else
        begin
            terminal_o <= term_req_i;
            if (feedback_o < level_i)
                feedback_o <= (level_i - feedback_o > step_i) ?
                    feedback_o + step_i : level_i;
            else if (feedback_o > level_i)
                feedback_o <= (feedback_o - level_i > step_i) ?
                    feedback_o - step_i : level_i;
        end
endmodule // ppf_process_model

// ===== dv/test_process_pid_frequency_controller.sv
// self-checking bench for the process regulator
// uses ppf_process_model as sensor and terminals
`timescale 1ns/1ns
`include "ppf_consts.vh"
module test_process_pid_frequency_controller;
    logic clk_i, rst_b_i, run_i;
    logic [15:0] reference_i, feedback_i, manual_command_i;
    logic [15:0] proportional_gain_i, alternate_gain_i, integral_time_i;
    logic [15:0] derivative_time_i, feed_forward_gain_i, output_scale_i;
    logic [15:0] limit_high_i, limit_low_i, pre_regulation_frequency_i;
    logic [15:0] pre_regulation_exit_level_i, pre_regulation_delay_i;
    logic [15:0] sleep_frequency_threshold_i, sleep_delay_i, wake_threshold_i;
    logic [2:0] gain_scale_shift_i;
    logic [3:0] output_lowpass_setting_i;
    logic [1:0] wake_mode_i;
    logic [4:0] terminal_i, term_req;
    logic [29:0] terminal_fn_i;
    logic [15:0] frequency_command_o, regulator_output_o, level, step;
    logic pre_regulation_failure_trip_o, sleep_active_o, closed_loop_o;
    logic output_blocked_o;
    int errors, samples_checked;

    ppf_regulator dut_u (.*);
    ppf_process_model model_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .level_i(level), .step_i(step), .term_req_i(term_req),
        .feedback_o(feedback_i), .terminal_o(terminal_i));

    task check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task wait_new(input logic [15:0] old);
        int k;
        k = 0;
        while (regulator_output_o === old && k < 26000)
        begin
            cyc(1);
            k++;
        end
    endtask
    task stop_test;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task t_reset;
        cyc(1);
        check(frequency_command_o, '0);
        check(regulator_output_o, '0);
        check({15'h0, output_blocked_o}, '0);
    endtask
    task t_pre;
        @(posedge clk_i);
        run_i <= 1'b1;
        cyc(4);
        check(frequency_command_o, 16'h012C);
        check({15'h0, closed_loop_o}, '0);
        check({15'h0, pre_regulation_failure_trip_o}, '0);
        @(posedge clk_i);
        level <= 16'h0258;
        cyc(10);
        check({15'h0, closed_loop_o}, 16'h0001);
        check(regulator_output_o, '0);
    endtask
    task t_bypass;
        @(posedge clk_i);
        term_req <= 5'h01;
        cyc(10);
        check({15'h0, closed_loop_o}, '0);
        check(frequency_command_o, 16'h007B);
        @(posedge clk_i);
        term_req <= '0;
        cyc(10);
        check({15'h0, closed_loop_o}, 16'h0001);
    endtask
    task t_prop;
        wait_new('0);
        check(regulator_output_o, 16'h00C8);
        cyc(3);
        check(frequency_command_o, 16'h00C8);
    endtask
    task t_gain2;
        @(posedge clk_i);
        term_req <= 5'h02;
        wait_new(16'h00C8);
        check(regulator_output_o, 16'h0096);
    endtask
    task t_sleep;
        int k;
        @(posedge clk_i);
        term_req <= 5'h04;
        feed_forward_gain_i <= 16'h01F4;
        limit_high_i <= 16'h0320;
        wait_new(16'h0096);
        check(regulator_output_o, 16'h02BC);
        @(posedge clk_i);
        sleep_frequency_threshold_i <= 16'h0320;
        k = 0;
        while (sleep_active_o !== 1'b1 && k < 26000)
        begin
            cyc(1);
            k++;
        end
        check({15'h0, sleep_active_o}, 16'h0001);
        check({15'h0, output_blocked_o}, 16'h0001);
        cyc(3);
        check(frequency_command_o, '0);
        @(posedge clk_i);
        wake_mode_i <= `PPF_WAKE_BEYOND;
        wake_threshold_i <= 16'h01F4;
        cyc(3);
        check({15'h0, sleep_active_o}, 16'h0001);
        @(posedge clk_i);
        wake_mode_i <= `PPF_WAKE_ABOVE;
        sleep_frequency_threshold_i <= '0;
        cyc(3);
        check({15'h0, sleep_active_o}, '0);
        check({15'h0, closed_loop_o}, 16'h0001);
        @(posedge clk_i);
        run_i <= 1'b0;
        cyc(3);
        check(frequency_command_o, '0);
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (80000) @(posedge clk_i);
        errors++;
        stop_test;
    end
    initial
    begin
        errors = 0;
        samples_checked = 0;
        rst_b_i = 1'b0;
        run_i = 1'b0;
        reference_i = 16'h03E8;
        manual_command_i = 16'h007B;
        proportional_gain_i = 16'h01F4;
        alternate_gain_i = 16'h00FA;
        integral_time_i = 16'h0002;
        derivative_time_i = '0;
        feed_forward_gain_i = '0;
        output_scale_i = 16'h03E8;
        limit_high_i = 16'h03E8;
        limit_low_i = '0;
        pre_regulation_frequency_i = 16'h012C;
        pre_regulation_exit_level_i = 16'h01F4;
        pre_regulation_delay_i = '0;
        sleep_frequency_threshold_i = '0;
        sleep_delay_i = '0;
        wake_threshold_i = 16'h0064;
        wake_mode_i = `PPF_WAKE_BELOW;
        gain_scale_shift_i = '0;
        output_lowpass_setting_i = '0;
        terminal_fn_i = {12'h000, `PPF_FN_ICLR, `PPF_FN_GAIN2, `PPF_FN_BYPASS};
        level = 16'h00C8;
        step = 16'h0064;
        term_req = '0;
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_reset;
        t_pre;
        t_bypass;
        t_prop;
        t_gain2;
        t_sleep;
        stop_test;
    end
endmodule // test_process_pid_frequency_controller
